// ===== bench/asrc_audio_partner.sv
`timescale 1ns/10ps
`default_nettype none
module asrc_audio_partner
  import asrc_pkg::*;
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Bench control
  input wire logic i_run,
  input wire logic i_burst,
  input wire logic [15:0] i_period,
  input wire logic [23:0] i_level,
  // Source side
  input wire logic i_ready,
  output logic o_valid,
  output asrc_pair_t o_data,
  // Destination side
  output logic o_stb,
  output logic [15:0] o_taken
);
  logic [15:0] cnt_reg;

  // Frame counter; strobe sits mid-period so it never meets a sample outside a burst
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || cnt_reg >= i_period - 16'h0001) cnt_reg <= 16'h0000;
    else cnt_reg <= cnt_reg + 16'h0001;
  end

  // One-cycle strobe per period
  always_ff @(posedge i_clk_sys) o_stb <= !i_rst && i_run && cnt_reg == (i_period >> 1);

  // Offer held until taken; a burst offers every cycle
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) o_valid <= 1'b0;
    else if (i_burst || (i_run && cnt_reg == 16'h0000)) o_valid <= 1'b1;
    else if (i_ready) o_valid <= 1'b0;
  end

  // Accepted words
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) o_taken <= 16'h0000;
    else if (o_valid && i_ready) o_taken <= o_taken + 16'h0001;
  end

  // Idle data keeps moving so a stale word never looks valid
  assign o_data = o_valid ? {i_level, 24'h000000 - i_level} : {2{~i_level ^ {8'h00, cnt_reg}}};
endmodule : asrc_audio_partner
`default_nettype wire

// ===== bench/asrc_core_sva.sv
`timescale 1ns/10ps
`default_nettype none
module asrc_core_sva
  import asrc_pkg::*;
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Streams
  input wire logic i_in_valid,
  input wire asrc_pair_t i_in_data,
  input wire logic o_in_ready,
  input wire logic i_out_stb,
  input wire asrc_pair_t o_out_data,
  input wire logic o_out_valid,
  // Register and status
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [7:0] o_reg_rdata,
  input wire logic o_fast_mode,
  input wire logic o_settled_evt
);
  logic busy_reg;
  logic [10:0] busy_cnt_reg;
  logic accept;

  // Sequencer is idle again in the cycle its result appears
  assign accept = i_out_stb && (!busy_reg || o_out_valid);

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);

  // Mirror of the sequencer; strobes while busy are dropped
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) busy_reg <= 1'b0;
    else if (accept) busy_reg <= 1'b1;
    else if (o_out_valid) busy_reg <= 1'b0;
  end

  // Cycles since the accepted strobe, saturating
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) busy_cnt_reg <= 11'h000;
    else if (accept) busy_cnt_reg <= 11'h001;
    else if (!busy_reg || o_out_valid) busy_cnt_reg <= 11'h000;
    else if (busy_cnt_reg != 11'h7ff) busy_cnt_reg <= busy_cnt_reg + 11'h001;
  end

  AST_RST_VALUES: assert property ($fell(i_rst) |-> o_fast_mode && o_in_ready && o_reg_rdata == 8'h00
    && !o_out_valid && !o_settled_evt) else $error("bad values after reset");
  AST_REG_ECHO: assert property (i_reg_wr |=> o_reg_rdata == $past(i_reg_wdata))
    else $error("register write not shown");
  AST_REG_HOLD: assert property (!i_reg_wr |=> $stable(o_reg_rdata))
    else $error("register changed without write");
  AST_EVT_FALL: assert property (o_settled_evt |-> $fell(o_fast_mode))
    else $error("settle event without leaving fast mode");
  AST_FAST_EXIT: assert property ($fell(o_fast_mode) |-> o_settled_evt)
    else $error("fast mode left without event");
  AST_EVT_PULSE: assert property (o_settled_evt |=> !o_settled_evt)
    else $error("settle event longer than one cycle");
  AST_VALID_GAP: assert property (o_out_valid |=> !o_out_valid [*8])
    else $error("results too close together");
  AST_CONV_WINDOW: assert property (accept |-> ##[127:1000] o_out_valid)
    else $error("no result after strobe");
  AST_VALID_BUSY: assert property (o_out_valid |-> busy_reg && busy_cnt_reg >= 11'h07f)
    else $error("result without full convolution");
  AST_DATA_HOLD: assert property (!o_out_valid |-> $stable(o_out_data))
    else $error("output data changed without result");

  COV_RESULT: cover property (o_out_valid);
  COV_SETTLED: cover property (o_settled_evt);
  COV_FULL: cover property (i_in_valid && !o_in_ready);
  COV_MUTE: cover property (i_reg_wr && i_reg_wdata[7]);
endmodule : asrc_core_sva

bind asrc_core asrc_core_sva asrc_core_sva_inst (
  .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_in_valid(i_in_valid), .i_in_data(i_in_data),
  .o_in_ready(o_in_ready), .i_out_stb(i_out_stb), .o_out_data(o_out_data), .o_out_valid(o_out_valid),
  .i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
  .o_fast_mode(o_fast_mode), .o_settled_evt(o_settled_evt)
);
`default_nettype wire

// ===== bench/asrc_core_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module asrc_core_tb_top;
  import asrc_pkg::*;
  logic i_clk_sys;
  logic i_rst;
  logic run, burst, reg_wr, in_valid, out_stb, in_ready, out_valid, fast, evt;
  logic [15:0] period, taken, mark, need;
  logic [7:0] reg_wdata, reg_rdata;
  asrc_pair_t in_data, out_data;
  int errors, compares;
  logic [7:0] reg_tab [5] = '{8'h00, 8'h7f, 8'h80, 8'hff, 8'h05};

  asrc_core asrc_core_inst (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_in_valid(in_valid),
    .i_in_data(in_data), .o_in_ready(in_ready), .i_out_stb(out_stb), .o_out_data(out_data),
    .o_out_valid(out_valid), .i_reg_wr(reg_wr), .i_reg_wdata(reg_wdata), .o_reg_rdata(reg_rdata),
    .o_fast_mode(fast), .o_settled_evt(evt));
  asrc_audio_partner asrc_audio_partner_inst (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_run(run),
    .i_burst(burst), .i_period(period), .i_level(24'h100000), .i_ready(in_ready),
    .o_valid(in_valid), .o_data(in_data), .o_stb(out_stb), .o_taken(taken));

  // 10 MHz
  initial begin
    i_clk_sys = 1'b0;
    forever #50 i_clk_sys = ~i_clk_sys;
  end

  task automatic check(input string name, input logic [47:0] seen, input logic [47:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic conclude;
    $display("counts: %0d compares, %0d errors", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude

  // Condition table for bounded waits
  function automatic logic hit(input int which);
    case (which)
      0: return out_valid;
      1: return evt;
      2: return !in_ready;
      3: return in_ready;
      4: return out_stb;
      default: return (taken - mark) >= need;
    endcase
  endfunction : hit

  // Looks just after the edge, once registered outputs have landed
  task automatic wait_for(input int which, input int limit);
    int n;
    n = 0;
    @(posedge i_clk_sys);
    #1;
    while (hit(which) !== 1'b1) begin
      n++;
      if (n > limit) begin
        errors++;
        $display("[ERR] wait %0d expected 1 seen timeout", which);
        conclude();
      end
      @(posedge i_clk_sys);
      #1;
    end
  endtask : wait_for

  task automatic wait_samples(input logic [15:0] n, input int limit);
    mark = taken;
    need = n;
    wait_for(5, limit);
  endtask : wait_samples

  task automatic reset_dut;
    @(posedge i_clk_sys);
    i_rst <= 1'b1;
    repeat (10) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    #1;
  endtask : reset_dut

  // Single-byte register port: value visible the cycle after the write
  task automatic reg_write(input logic [7:0] v);
    @(posedge i_clk_sys);
    reg_wr <= 1'b1;
    reg_wdata <= v;
    @(posedge i_clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask : reg_write

  task automatic reg_read(input logic [7:0] exp);
    check("reg_rdata", reg_rdata, exp);
  endtask : reg_read

  initial begin
    errors = 0;
    compares = 0;
    i_rst = 1'b1;
    run = 1'b0;
    burst = 1'b0;
    period = 16'h0087;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    mark = 16'h0000;
    need = 16'h0000;
    reset_dut();
    check("fast_after_reset", fast, 1'b1);
    check("ready_after_reset", in_ready, 1'b1);
    reg_read(8'h00);
    foreach (reg_tab[k]) begin
      reg_write(reg_tab[k]);
      reg_read(reg_tab[k]);
    end
    reg_write(8'h00);
    $display("test registers done");

    // FIFO fills while the convolution holds off RAM writes
    @(posedge i_clk_sys);
    run <= 1'b1;
    wait_for(4, 300);
    @(posedge i_clk_sys);
    burst <= 1'b1;
    #1;
    mark = taken;
    wait_for(2, 100);
    check("fifo_fill_count", taken - mark, 16'h0010);
    wait_for(0, 1100);
    @(posedge i_clk_sys);
    burst <= 1'b0;
    wait_for(3, 400);
    $display("test fifo done");

    // Second reset mid-run, then settle at equal rates
    @(posedge i_clk_sys);
    run <= 1'b0;
    reset_dut();
    check("fast_after_rerun", fast, 1'b1);
    @(posedge i_clk_sys);
    run <= 1'b1;
    wait_for(0, 300);
    check("fast_while_settling", fast, 1'b1);
    wait_for(1, 20000);
    check("fast_after_event", fast, 1'b0);
    wait_samples(16'h0050, 12000);
    wait_for(0, 300);
    check("stereo_signs", {out_data.left[23], out_data.right[23], out_data.left != 0,
      out_data.right != 0}, 4'b0111);
    $display("test settle done");

    // Soft mute ramps to silence, unmute restores
    reg_write(8'h80);
    wait_samples(16'h0154, 50000);
    wait_for(0, 300);
    check("muted_output", out_data, 48'h000000000000);
    reg_write(8'h00);
    wait_samples(16'h0050, 12000);
    wait_for(0, 300);
    check("unmuted_signs", {out_data.left[23], out_data.right[23], out_data.left != 0,
      out_data.right != 0}, 4'b0111);
    $display("test mute done");
    conclude();
  end
endmodule : asrc_core_tb_top
`default_nettype wire

// ===== rtl/asrc_core.sv
// Contract
// - Output picks nearest sample on a 2^20 interpolation grid, low-pass filtered.
// - 64 taps when upsampling; ratio times 64 taps when downsampling.
// - One convolution per output period, only non-zero polyphase products.
// - Output arrival found by averaging coarse period measurements over time.
// - Coefficient ROM holds a subset; intermediate coefficients are interpolated.
// - When downsampling, input samples scaled by output/input ratio before RAM.
// - Gain ramp on incoming samples gives soft mute and unmute.
// - Sample RAM holds 512 words per channel.
// - Write pointer leads by 16 plus delay register bits 6..0.
// - Delay register bit 7 set mutes softly, clear unmutes.
// - Servo ramp integer part gives RAM start, fraction gives ROM start.
// - When downsampling, fractional ROM start is divided by input/output ratio.
// - Fast servo mode at startup or rate change; slow once settled.
// - Fast-mode status flag held high while servo is in fast mode.
// - Event raised on return from fast to slow mode.
// - Load pointers per period; per tap RAM minus 1, ROM plus step.
// - A channel's convolution ends when the ROM pointer rolls over.
// - One multiply-accumulate unit shared by left and right.
// - Ratio from output and input counters; forced to one when upsampling.
// - Downsampling ratio updated only when it moves by more than two.
// - Input counter gives RAM write address and servo ramp input.
`timescale 1ns/10ps
`default_nettype none
`include "asrc_defs.svh"
module asrc_core
  import asrc_pkg::*;
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Input sample stream
  input wire logic i_in_valid,
  input wire asrc_pair_t i_in_data,
  output logic o_in_ready,
  // Output sample strobe and result
  input wire logic i_out_stb,
  output asrc_pair_t o_out_data,
  output logic o_out_valid,
  // Delay and mute register
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  // Servo status
  output logic o_fast_mode,
  output logic o_settled_evt
);

  // Unsigned divide, shared by servo and ratio arithmetic
  function automatic logic [31:0] div_u(input logic [31:0] num, input logic [15:0] den);
    div_u = (den == 16'h0000) ? 32'hffffffff : num / {16'h0000, den};
  endfunction : div_u

  // Signed sample times Q8 gain
  function automatic logic signed [23:0] mul_q8(input logic signed [23:0] s, input logic [9:0] g);
    logic signed [34:0] p;
    p = s * $signed({1'b0, g});
    mul_q8 = p[31:8];
  endfunction : mul_q8

  // Accumulator back to a saturated sample
  function automatic logic signed [23:0] sat_out(input logic signed [49:0] a);
    if (a[49:38] != {12{a[38]}}) begin
      sat_out = a[49] ? 24'sh800000 : 24'sh7fffff;
    end else begin
      sat_out = a[38:15];
    end
  endfunction : sat_out

  // Stored kernel points, half a window; mirrored for the other half
  function automatic logic [15:0] rom_pt(input logic [5:0] k);
    logic [4:0] m;
    m = (k > 6'h10) ? 5'(6'h20 - k) : k[4:0];
    case (m)
      5'h00: rom_pt = 16'h0000;
      5'h01: rom_pt = 16'h013b;
      5'h02: rom_pt = 16'h04df;
      5'h03: rom_pt = 16'h0ac9;
      5'h04: rom_pt = 16'h12bf;
      5'h05: rom_pt = 16'h1c71;
      5'h06: rom_pt = 16'h2782;
      5'h07: rom_pt = 16'h3383;
      5'h08: rom_pt = 16'h4000;
      5'h09: rom_pt = 16'h4c7c;
      5'h0a: rom_pt = 16'h587d;
      5'h0b: rom_pt = 16'h638e;
      5'h0c: rom_pt = 16'h6d40;
      5'h0d: rom_pt = 16'h7536;
      5'h0e: rom_pt = 16'h7b20;
      5'h0f: rom_pt = 16'h7ec4;
      5'h10: rom_pt = 16'h7fff;
      default: rom_pt = 16'h0000;
    endcase
  endfunction : rom_pt

  // Coefficient between stored points; linear to keep the MAC single-cycle
  function automatic logic [15:0] coef_at(input logic [25:0] p);
    logic [15:0] a;
    logic [15:0] b;
    logic signed [25:0] d;
    a = rom_pt({1'b0, p[25:21]});
    b = rom_pt(6'(p[25:21]) + 6'h01);
    d = ($signed({1'b0, b}) - $signed({1'b0, a})) * $signed({1'b0, p[20:13]});
    coef_at = 16'($signed({1'b0, a}) + (d >>> 8));
  endfunction : coef_at

  // Sample RAM, one array per channel
  logic signed [23:0] ram_l [512];
  logic signed [23:0] ram_r [512];

  // Input buffering
  asrc_pair_t fifo_data;
  logic fifo_valid;
  logic fifo_pop;
  asrc_conv_t conv_reg;

  // RAM write is held off during convolution, so the FIFO takes the slack
  assign fifo_pop = fifo_valid && (conv_reg == CONV_IDLE);

  asrc_fifo #(
    .WIDTH(48),
    .DEPTH(`ASRC_FIFO_DEPTH)
  ) u_fifo (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_valid(i_in_valid),
    .i_data(i_in_data),
    .o_ready(o_in_ready),
    .o_valid(fifo_valid),
    .o_data(fifo_data),
    .i_ready(fifo_pop)
  );

  // Delay and mute register
  logic [7:0] delay_reg;
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      delay_reg <= `ASRC_DELAY_RST;
    end else if (i_reg_wr) begin
      delay_reg <= i_reg_wdata;
    end
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_reg_rdata <= `ASRC_DELAY_RST;
    end else begin
      o_reg_rdata <= i_reg_wr ? i_reg_wdata : delay_reg;
    end
  end

  // Soft-mute gain ramps one step per accepted input sample
  logic [9:0] gain_reg;
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      gain_reg <= `ASRC_GAIN_FULL;
    end else if (fifo_pop) begin
      if (delay_reg[`ASRC_MUTE_BIT] && gain_reg != 10'h000) begin
        gain_reg <= gain_reg - 10'h001;
      end else if (!delay_reg[`ASRC_MUTE_BIT] && gain_reg != `ASRC_GAIN_FULL) begin
        gain_reg <= gain_reg + 10'h001;
      end
    end
  end

  // Input counter: write address base and servo ramp input
  logic [8:0] in_cnt_reg;
  logic [8:0] wr_addr;
  logic [9:0] inv_ratio_reg;
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      in_cnt_reg <= 9'h000;
    end else if (fifo_pop) begin
      in_cnt_reg <= in_cnt_reg + 9'h001;
    end
  end
  assign wr_addr = in_cnt_reg + `ASRC_MIN_LEAD + {2'b00, delay_reg[`ASRC_DELAY_MSB:`ASRC_DELAY_LSB]};

  // Scaled and ramped samples into RAM
  always_ff @(posedge i_clk_sys) begin
    if (fifo_pop) begin
      ram_l[wr_addr] <= mul_q8(mul_q8(fifo_data.left, gain_reg), inv_ratio_reg);
      ram_r[wr_addr] <= mul_q8(mul_q8(fifo_data.right, gain_reg), inv_ratio_reg);
    end
  end

  // Input period: clocks since last sample, averaged to beat coarse quantisation
  logic [15:0] t_since_reg;
  logic [15:0] t_in_reg;
  logic signed [16:0] t_err;
  assign t_err = $signed({1'b0, t_since_reg}) - $signed({1'b0, t_in_reg});
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      t_since_reg <= 16'h0000;
      t_in_reg <= `ASRC_TIN_RST;
    end else if (fifo_pop) begin
      t_since_reg <= 16'h0000;
      t_in_reg <= 16'($signed({1'b0, t_in_reg}) + (t_err >>> 3));
    end else if (t_since_reg != 16'hffff) begin
      t_since_reg <= t_since_reg + 16'h0001;
    end
  end

  // Ratio: input samples counted over sixteen output periods
  logic [3:0] out_win_reg;
  logic [7:0] in_win_reg;
  logic [7:0] ratio_reg;
  logic [7:0] ratio_new;
  logic [7:0] ratio_diff;
  logic rate_chg;
  assign ratio_new = (in_win_reg <= `ASRC_RATIO_ONE) ? `ASRC_RATIO_ONE :
                     (in_win_reg > `ASRC_RATIO_MAX) ? `ASRC_RATIO_MAX : in_win_reg;
  assign ratio_diff = (ratio_new > ratio_reg) ? ratio_new - ratio_reg : ratio_reg - ratio_new;
  // Hysteresis stops the filter length from hunting
  assign rate_chg = i_out_stb && (out_win_reg == `ASRC_RATIO_WIN) &&
                    ((ratio_new == `ASRC_RATIO_ONE) ? (ratio_reg != `ASRC_RATIO_ONE)
                                                    : (ratio_diff > `ASRC_RATIO_HYST));
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      out_win_reg <= 4'h0;
      in_win_reg <= 8'h00;
    end else if (i_out_stb && out_win_reg == `ASRC_RATIO_WIN) begin
      out_win_reg <= 4'h0;
      in_win_reg <= {7'h00, fifo_pop};
    end else begin
      if (i_out_stb) begin
        out_win_reg <= out_win_reg + 4'h1;
      end
      if (fifo_pop && in_win_reg != 8'hff) begin
        in_win_reg <= in_win_reg + 8'h01;
      end
    end
  end

  // Ratio and the quantities derived from it
  logic [26:0] rom_step_reg;
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      ratio_reg <= `ASRC_RATIO_ONE;
      inv_ratio_reg <= `ASRC_GAIN_FULL;
      rom_step_reg <= `ASRC_ONE_STEP;
    end else if (rate_chg) begin
      ratio_reg <= ratio_new;
      inv_ratio_reg <= 10'(div_u(32'h00001000, {8'h00, ratio_new}));
      rom_step_reg <= 27'(div_u(32'h01000000, {8'h00, ratio_new}));
    end
  end

  // Measured input position at the output strobe, 9.20 fixed point
  logic [28:0] pos_meas;
  logic [31:0] frac_q;
  assign frac_q = div_u({t_since_reg, 16'h0000}, t_in_reg) << 4;
  assign pos_meas = {in_cnt_reg, (frac_q[31:20] != 12'h000) ? 20'hfffff : frac_q[19:0]};

  // Ramp filter: predicted position plus shifted error
  logic [28:0] est_pos_reg;
  logic [28:0] est_inc_reg;
  logic [28:0] pred;
  logic signed [28:0] serr;
  logic [28:0] est_pos_next;
  logic [4:0] kp;
  logic [4:0] ki;
  logic fast_reg;
  assign kp = fast_reg ? `ASRC_KP_FAST : `ASRC_KP_SLOW;
  assign ki = fast_reg ? `ASRC_KI_FAST : `ASRC_KI_SLOW;
  assign pred = est_pos_reg + est_inc_reg;
  assign serr = $signed(pos_meas - pred);
  assign est_pos_next = pred + 29'(serr >>> kp);
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      est_pos_reg <= 29'h0000000;
      est_inc_reg <= 29'h0000000;
    end else if (i_out_stb) begin
      est_pos_reg <= est_pos_next;
      est_inc_reg <= est_inc_reg + 29'(serr >>> ki);
    end
  end

  // Settling: error small for a run of output periods
  logic [5:0] settle_cnt_reg;
  logic small_err;
  assign small_err = (serr < $signed(`ASRC_SETTLE_THR)) && (serr > -$signed(`ASRC_SETTLE_THR));
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      fast_reg <= 1'b1;
      settle_cnt_reg <= 6'h00;
      o_settled_evt <= 1'b0;
    end else begin
      o_settled_evt <= 1'b0;
      if (rate_chg) begin
        fast_reg <= 1'b1;
        settle_cnt_reg <= 6'h00;
      end else if (i_out_stb && fast_reg) begin
        if (!small_err) begin
          settle_cnt_reg <= 6'h00;
        end else if (settle_cnt_reg == `ASRC_SETTLE_N - 6'h01) begin
          fast_reg <= 1'b0;
          o_settled_evt <= 1'b1;
          settle_cnt_reg <= 6'h00;
        end else begin
          settle_cnt_reg <= settle_cnt_reg + 6'h01;
        end
      end
    end
  end
  // Status flag falls in the event's own cycle, not one cycle later
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_fast_mode <= 1'b1;
    end else begin
      o_fast_mode <= rate_chg || (fast_reg && !(i_out_stb && small_err &&
                     settle_cnt_reg == `ASRC_SETTLE_N - 6'h01));
    end
  end

  // Start pointers; fraction stretched when downsampling
  logic [8:0] ram_start;
  logic [26:0] rom_start;
  assign ram_start = est_pos_next[28:20];
  assign rom_start = (ratio_reg == `ASRC_RATIO_ONE) ? {7'h00, est_pos_next[19:0]}
                   : 27'(div_u({8'h00, est_pos_next[19:0], 4'h0}, {8'h00, ratio_reg}));

  // Convolution: one pass per output strobe taken in CONV_IDLE, left then right on one MAC
  logic [8:0] ram_ptr_reg;
  logic [26:0] rom_ptr_reg;
  logic [8:0] ram_start_reg;
  logic [26:0] rom_start_reg;
  logic signed [49:0] acc_reg;
  logic signed [23:0] left_reg;
  logic signed [23:0] tap_sample;
  logic signed [40:0] product;
  logic [27:0] rom_sum;
  assign tap_sample = (conv_reg == CONV_RIGHT) ? ram_r[ram_ptr_reg] : ram_l[ram_ptr_reg];
  assign product = tap_sample * $signed({1'b0, coef_at(rom_ptr_reg[25:0])});
  assign rom_sum = {1'b0, rom_ptr_reg} + {1'b0, rom_step_reg};

  // Strobes that arrive mid-convolution are skipped
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      conv_reg <= CONV_IDLE;
      ram_ptr_reg <= 9'h000;
      rom_ptr_reg <= 27'h0000000;
      ram_start_reg <= 9'h000;
      rom_start_reg <= 27'h0000000;
      acc_reg <= '0;
      left_reg <= '0;
    end else begin
      case (conv_reg)
        CONV_IDLE: begin
          if (i_out_stb) begin
            ram_ptr_reg <= ram_start;
            rom_ptr_reg <= rom_start;
            ram_start_reg <= ram_start;
            rom_start_reg <= rom_start;
            acc_reg <= '0;
            conv_reg <= CONV_LEFT;
          end
        end
        CONV_LEFT: begin
          acc_reg <= acc_reg + 50'(product);
          ram_ptr_reg <= ram_ptr_reg - 9'h001;
          rom_ptr_reg <= rom_sum[26:0];
          if (rom_sum[26]) begin
            left_reg <= sat_out(acc_reg + 50'(product));
            acc_reg <= '0;
            ram_ptr_reg <= ram_start_reg;
            rom_ptr_reg <= rom_start_reg;
            conv_reg <= CONV_RIGHT;
          end
        end
        CONV_RIGHT: begin
          acc_reg <= acc_reg + 50'(product);
          ram_ptr_reg <= ram_ptr_reg - 9'h001;
          rom_ptr_reg <= rom_sum[26:0];
          if (rom_sum[26]) begin
            conv_reg <= CONV_IDLE;
          end
        end
        default: begin
          conv_reg <= CONV_IDLE;
        end
      endcase
    end
  end

  // Result registers
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_out_data <= '0;
      o_out_valid <= 1'b0;
    end else begin
      o_out_valid <= 1'b0;
      if (conv_reg == CONV_RIGHT && rom_sum[26]) begin
        o_out_data.left <= left_reg;
        o_out_data.right <= sat_out(acc_reg + 50'(product));
        o_out_valid <= 1'b1;
      end
    end
  end

endmodule : asrc_core
`default_nettype wire

// ===== rtl/asrc_defs.svh
`ifndef ASRC_DEFS_SVH
`define ASRC_DEFS_SVH

// Sample and storage geometry
`define ASRC_SAMPLE_W 24
`define ASRC_RAM_AW 9
`define ASRC_FIFO_DEPTH 16
// Interpolation grid: 20 fraction bits, 64 base taps
`define ASRC_FRAC_BITS 20
`define ASRC_TAP_BITS 6
`define ASRC_ONE_STEP 27'h0100000
// Write-pointer lead and delay register fields
`define ASRC_MIN_LEAD 9'h010
`define ASRC_DELAY_LSB 0
`define ASRC_DELAY_MSB 6
`define ASRC_MUTE_BIT 7
`define ASRC_DELAY_RST 8'h00
// Ratio in Q4: 16 means one; 124 is the RAM limit of 7.75
`define ASRC_RATIO_ONE 8'h10
`define ASRC_RATIO_MAX 8'h7c
`define ASRC_RATIO_HYST 8'h02
`define ASRC_RATIO_WIN 4'hf
// Gain ramp, Q8
`define ASRC_GAIN_FULL 10'h100
// Servo loop gains and settling test
`define ASRC_KP_FAST 5'h01
`define ASRC_KI_FAST 5'h03
`define ASRC_KP_SLOW 5'h04
`define ASRC_KI_SLOW 5'h08
`define ASRC_SETTLE_THR 29'h0010000
`define ASRC_SETTLE_N 6'h20
`define ASRC_TIN_RST 16'h00d0

`endif

// ===== rtl/asrc_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module asrc_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Fill side
  input wire logic i_valid,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_ready,
  // Drain side
  output logic o_valid,
  output logic [WIDTH-1:0] o_data,
  input wire logic i_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr_reg;
  logic [AW:0] rd_ptr_reg;
  logic full;
  logic empty;
  logic push;
  logic pop;

  // Extra pointer bit tells full from empty
  assign full = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
  assign empty = (wr_ptr_reg == rd_ptr_reg);
  assign push = i_valid && !full;
  assign pop = i_ready && !empty;
  assign o_ready = !full;
  assign o_valid = !empty;
  assign o_data = mem[rd_ptr_reg[AW-1:0]];

  // Storage
  always_ff @(posedge i_clk_sys) begin
    if (push) begin
      mem[wr_ptr_reg[AW-1:0]] <= i_data;
    end
  end

  // Pointers
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end
endmodule : asrc_fifo
`default_nettype wire

// ===== rtl/asrc_pkg.sv
package asrc_pkg;

  // One stereo sample
  typedef struct packed {
    logic signed [23:0] left;
    logic signed [23:0] right;
  } asrc_pair_t;

  // Convolution sequencer
  typedef enum logic [1:0] {
    CONV_IDLE,
    CONV_LEFT,
    CONV_RIGHT
  } asrc_conv_t;

endpackage : asrc_pkg
